// [rtl/fault_regs.svh]
// register offsets, field positions, reset values and timing counts
// for the switch fault protection block; definitions only
`ifndef FAULT_REGS_SVH
`define FAULT_REGS_SVH

`define GENERAL_CFG_OFFSET    12'h000
`define OC_CFG_OFFSET         12'h004
`define CHAN_FAULT0_OFFSET    12'h008
`define CHAN_FAULT1_OFFSET    12'h00c
`define COMMON_STATUS_OFFSET  12'h010

`define GCFG_OVDIS_BIT        0
`define GCFG_SRC_LSB          1
`define GCFG_RETRY_EN_LSB     3
`define GCFG_RETRY_LIM_LSB    8

`define OCFG_FIRST_LSB        0
`define OCFG_SECOND_LSB       16

`define FLT_OC_BIT            0
`define FLT_SC_BIT            1
`define FLT_OT_BIT            2
`define FLT_PROFILE_BIT       3
`define FLT_RETRIES_LSB       4

`define STAT_OV_BIT           0
`define STAT_UV_BIT           1
`define STAT_IND_BIT          2

`define WIDTH_FIRST_RESET     16'h0100
`define WIDTH_SECOND_RESET    16'h0200
`define RETRY_LIMIT_RESET     4'h0

`define CLK_PERIOD_NS         10
`define T_FAULT_NS            20
`define FAULT_RESP_CYC \
  ((`T_FAULT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [rtl/fault_pkg.sv]
// types shared by the switch fault protection block and its bench
// assumes an apb3 style master and asynchronous comparator pins
package fault_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic hot;
    logic over_low;
    logic over_mid;
    logic over_high;
    logic short_det;
  } chan_cmp_t;

  typedef struct packed {
    logic overvolt;
    logic ov_released;
    logic undervolt;
  } supply_cmp_t;

  typedef struct packed {
    supply_cmp_t     sup;
    chan_cmp_t [1:0] ch;
    logic [1:0]      load_profile_select;
  } pin_in_t;

  typedef struct packed {
    logic [1:0] request;
    logic [1:0] switch_mode;
    logic [1:0] delatch;
  } chan_ctl_t;

  typedef enum logic [1:0] {WIN_NONE, WIN_FIRST, WIN_SECOND} win_phase_t;

  typedef struct packed {
    pin_in_t          sync1;
    pin_in_t          sync2;
    apb_rsp_t         rsp;
    logic             ovdis;
    logic [1:0]       src_sel;
    logic [1:0]       retry_en;
    logic [3:0]       retry_limit;
    logic [15:0]      width_first;
    logic [15:0]      width_second;
    logic [1:0]       req_d;
    logic [1:0]       on;
    logic [1:0]       ot_stop;
    logic [1:0]       latch_oc;
    logic [1:0]       latch_sc;
    logic [1:0]       uv_lock;
    logic [1:0]       retry_pend;
    logic [1:0]       started;
    logic [1:0]       clean;
    logic [1:0]       blank;
    win_phase_t [1:0] phase;
    logic [1:0][15:0] dur;
    logic [1:0][3:0]  retries;
    logic [1:0][1:0]  resp_cnt;
    logic [1:0]       oc_pend;
    logic [1:0]       ot_flag;
    logic [1:0]       oc_flag;
    logic [1:0]       sc_flag;
    logic             ov_flag;
    logic             uv_flag;
    logic             ov_block;
    logic             uv_d;
    logic             ind_n;
  } state_t;

endpackage

// [rtl/switch_fault_protection.sv]
// fault protection and diagnostic state for a two channel switch
// assumes comparator pins are asynchronous, channel control comes from
// logic on the same clock, and software reaches registers over apb
`timescale 1ns/1ps
`include "fault_regs.svh"

module switch_fault_protection (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               reset,
  // register bus
  input  wire fault_pkg::apb_req_t apb_req,
  output fault_pkg::apb_rsp_t      apb_rsp,
  // comparator and strap pins
  input  wire fault_pkg::pin_in_t  fault_pins,
  // channel control
  input  wire fault_pkg::chan_ctl_t chan_ctl,
  // outputs
  output logic [1:0]              channel_on,
  output logic                    fault_indicator_n,
  output logic [1:0]              sense_sync,
  output logic [1:0]              retry_restart
);
  import fault_pkg::*;

  state_t  state_r;
  state_t  state_nxt;
  pin_in_t cmp;
  logic    both_cool;
  logic    done;
  logic    rd_fault0;

  assign cmp       = state_r.sync2;
  assign both_cool = !cmp.ch[0].hot && !cmp.ch[1].hot;
  assign done      = apb_req.psel && apb_req.penable && state_r.rsp.pready;
  assign rd_fault0 = done && !apb_req.pwrite &&
                     (apb_req.paddr == `CHAN_FAULT0_OFFSET);

  always_comb begin
    logic        lighting;
    logic        oc_hit;
    logic        fire_oc;
    logic        fire_sc;
    logic        go_on;
    logic        turn_on_any;
    logic        fault_evt;
    logic        wr;
    logic        rd;
    logic        bad;
    logic [31:0] rdata;
    lighting    = 1'b0;
    oc_hit      = 1'b0;
    fire_oc     = 1'b0;
    fire_sc     = 1'b0;
    go_on       = 1'b0;
    turn_on_any = 1'b0;
    fault_evt   = 1'b0;
    wr          = done && apb_req.pwrite;
    rd          = done && !apb_req.pwrite;
    bad         = 1'b0;
    rdata       = 32'h0000_0000;
    state_nxt   = state_r;

    // the first stage feeds only the second one
    state_nxt.sync1 = fault_pins;
    state_nxt.sync2 = state_r.sync1;

    // one wait state: pready rises in the second access cycle
    state_nxt.rsp.pready = apb_req.psel && apb_req.penable &&
                           !state_r.rsp.pready;
    if (apb_req.paddr == `GENERAL_CFG_OFFSET) begin
      rdata[`GCFG_OVDIS_BIT]           = state_r.ovdis;
      rdata[`GCFG_SRC_LSB +: 2]        = state_r.src_sel;
      rdata[`GCFG_RETRY_EN_LSB +: 2]   = state_r.retry_en;
      rdata[`GCFG_RETRY_LIM_LSB +: 4]  = state_r.retry_limit;
      if (wr) begin
        state_nxt.ovdis       = apb_req.pwdata[`GCFG_OVDIS_BIT];
        state_nxt.src_sel     = apb_req.pwdata[`GCFG_SRC_LSB +: 2];
        state_nxt.retry_en    = apb_req.pwdata[`GCFG_RETRY_EN_LSB +: 2];
        state_nxt.retry_limit = apb_req.pwdata[`GCFG_RETRY_LIM_LSB +: 4];
      end
    end else if (apb_req.paddr == `OC_CFG_OFFSET) begin
      rdata[`OCFG_FIRST_LSB +: 16]  = state_r.width_first;
      rdata[`OCFG_SECOND_LSB +: 16] = state_r.width_second;
      if (wr) begin
        state_nxt.width_first  = apb_req.pwdata[`OCFG_FIRST_LSB +: 16];
        state_nxt.width_second = apb_req.pwdata[`OCFG_SECOND_LSB +: 16];
      end
    end else if (apb_req.paddr == `CHAN_FAULT0_OFFSET ||
                 apb_req.paddr == `CHAN_FAULT1_OFFSET) begin
      for (int i = 0; i < 2; i++) begin
        if (apb_req.paddr[2] == i[0]) begin
          rdata[`FLT_OC_BIT]         = state_r.oc_flag[i];
          rdata[`FLT_SC_BIT]         = state_r.sc_flag[i];
          rdata[`FLT_OT_BIT]         = state_r.ot_flag[i];
          rdata[`FLT_PROFILE_BIT]    = cmp.load_profile_select[i] ^
                                       state_r.src_sel[i];
          rdata[`FLT_RETRIES_LSB +: 4] = state_r.retries[i];
          if (rd) begin
            if (!cmp.ch[i].hot && state_r.ind_n)
              state_nxt.ot_flag[i] = 1'b0;
            if (!state_r.latch_oc[i])
              state_nxt.oc_flag[i] = 1'b0;
            if (!state_r.latch_sc[i])
              state_nxt.sc_flag[i] = 1'b0;
          end
        end
      end
    end else if (apb_req.paddr == `COMMON_STATUS_OFFSET) begin
      rdata[`STAT_OV_BIT]  = state_r.ov_flag;
      rdata[`STAT_UV_BIT]  = state_r.uv_flag;
      rdata[`STAT_IND_BIT] = state_r.ind_n;
      if (rd) begin
        if (!cmp.sup.overvolt)
          state_nxt.ov_flag = 1'b0;
        if (!cmp.sup.undervolt && |state_r.on)
          state_nxt.uv_flag = 1'b0;
      end
    end else begin
      bad = 1'b1;
    end
    if (state_nxt.rsp.pready) begin
      state_nxt.rsp.prdata  = rdata;
      state_nxt.rsp.pslverr = bad;
    end

    // supply monitors; a set later in this process wins over a read clear
    if (state_r.ov_block && cmp.sup.ov_released && !cmp.sup.overvolt)
      state_nxt.ov_block = 1'b0;
    if (cmp.sup.overvolt) begin
      state_nxt.ov_flag = 1'b1;
      if (!state_r.ovdis) begin
        state_nxt.ov_block = 1'b1;
        fault_evt          = 1'b1;
      end
    end
    if (cmp.sup.undervolt) begin
      state_nxt.uv_flag = 1'b1;
      fault_evt         = 1'b1;
    end
    state_nxt.uv_d = cmp.sup.undervolt;

    for (int i = 0; i < 2; i++) begin
      lighting = !(cmp.load_profile_select[i] ^ state_r.src_sel[i]);
      oc_hit   = 1'b0;
      state_nxt.retry_pend[i] = 1'b0;
      if (!state_r.on[i])
        state_nxt.oc_pend[i] = 1'b0;

      // undervolt with request held and retry off: stays off until delatch or the request drops
      if (!chan_ctl.request[i])
        state_nxt.uv_lock[i] = 1'b0;
      if (cmp.sup.undervolt && chan_ctl.request[i] && !state_r.retry_en[i])
        state_nxt.uv_lock[i] = 1'b1;

      // overtemperature, watched in on and off state
      if (cmp.ch[i].hot) begin
        state_nxt.ot_stop[i] = 1'b1;
        state_nxt.ot_flag[i] = 1'b1;
        fault_evt            = 1'b1;
      end else if (state_r.ot_stop[i] && (state_r.retry_en[i] ||
                   (chan_ctl.request[i] && !state_r.req_d[i]))) begin
        state_nxt.ot_stop[i] = 1'b0;
      end

      // overcurrent profile; counter runs only while on, so pwm off-time
      // is excluded rather than clearing the count
      if (state_r.on[i]) begin
        case (state_r.phase[i])
          WIN_NONE: begin
            if (lighting) begin
              oc_hit = cmp.ch[i].over_low;
            end else if (cmp.ch[i].over_low) begin
              state_nxt.phase[i] = WIN_FIRST;
              state_nxt.clean[i] = 1'b0;
            end
          end
          WIN_FIRST: begin
            state_nxt.dur[i] = state_r.dur[i] + 16'h0001;
            if (cmp.ch[i].over_high) begin
              oc_hit = 1'b1;
            end else if (lighting) begin
              if (state_r.dur[i] > state_r.width_first) begin
                state_nxt.phase[i] = WIN_SECOND;
                state_nxt.dur[i]   = 16'h0000;
              end
            end else if (state_r.dur[i] > state_r.width_first) begin
              oc_hit = 1'b1;
            end else if (!cmp.ch[i].over_low) begin
              state_nxt.phase[i] = WIN_NONE;
            end
          end
          WIN_SECOND: begin
            state_nxt.dur[i] = state_r.dur[i] + 16'h0001;
            if (cmp.ch[i].over_mid) begin
              oc_hit = 1'b1;
            end else if (state_r.dur[i] > state_r.width_second) begin
              state_nxt.phase[i] = WIN_NONE;
              state_nxt.dur[i]   = 16'h0000;
            end
          end
          default: state_nxt.phase[i] = WIN_NONE;
        endcase
      end

      // response delay before an overcurrent shutdown
      fire_oc = state_r.oc_pend[i] && state_r.resp_cnt[i] == 2'd0;
      if (state_r.oc_pend[i] && !fire_oc)
        state_nxt.resp_cnt[i] = state_r.resp_cnt[i] - 2'd1;
      if (oc_hit && !state_r.oc_pend[i]) begin
        state_nxt.oc_pend[i]  = 1'b1;
        state_nxt.resp_cnt[i] = 2'(`FAULT_RESP_CYC - 1);
      end
      fire_sc = state_r.on[i] && cmp.ch[i].short_det;
      if (fire_oc || fire_sc) begin
        state_nxt.oc_pend[i] = 1'b0;
        fault_evt            = 1'b1;
        if (fire_oc)
          state_nxt.oc_flag[i] = 1'b1;
        if (fire_sc)
          state_nxt.sc_flag[i] = 1'b1;
        if (state_r.retry_en[i] &&
            state_r.retries[i] < state_r.retry_limit) begin
          state_nxt.retries[i]    = state_r.retries[i] + 4'h1;
          state_nxt.retry_pend[i] = 1'b1;
          if (lighting)
            state_nxt.dur[i] = 16'h0000;
        end else begin
          state_nxt.latch_oc[i] = state_r.latch_oc[i] | fire_oc;
          state_nxt.latch_sc[i] = state_r.latch_sc[i] | fire_sc;
        end
      end

      // delatch wins over any counting in the same cycle
      if (chan_ctl.delatch[i]) begin
        state_nxt.latch_oc[i] = 1'b0;
        state_nxt.latch_sc[i] = 1'b0;
        state_nxt.dur[i]      = 16'h0000;
        state_nxt.retries[i]  = 4'h0;
        state_nxt.uv_lock[i]  = 1'b0;
        state_nxt.started[i]  = 1'b0;
        state_nxt.phase[i]    = WIN_NONE;
      end

      go_on = chan_ctl.request[i] && !state_nxt.latch_oc[i] &&
              !state_nxt.latch_sc[i] && !state_nxt.ot_stop[i] &&
              !state_nxt.uv_lock[i] && !state_nxt.retry_pend[i] &&
              !cmp.sup.undervolt && !state_nxt.ov_block && !fire_oc &&
              !fire_sc;
      state_nxt.on[i] = go_on;
      if (go_on && !state_r.on[i]) begin
        turn_on_any          = 1'b1;
        state_nxt.clean[i]   = 1'b1;
        if (lighting && (!chan_ctl.switch_mode[i] ||
                         !state_r.started[i])) begin
          state_nxt.phase[i]   = WIN_FIRST;
          state_nxt.dur[i]     = 16'h0000;
          state_nxt.started[i] = 1'b1;
        end
      end
      if (!go_on && state_r.on[i] && !lighting && state_r.clean[i] &&
          !chan_ctl.switch_mode[i]) begin
        state_nxt.dur[i]   = 16'h0000;
        state_nxt.phase[i] = WIN_NONE;
      end
      state_nxt.blank[i] = state_nxt.phase[i] != WIN_NONE;
      state_nxt.req_d[i] = chan_ctl.request[i];
    end

    // indicator: release first so that a fresh fault in the cycle wins
    if ((turn_on_any && both_cool) ||
        (state_r.uv_d && !cmp.sup.undervolt && !(|chan_ctl.request)))
      state_nxt.ind_n = 1'b1;
    if (fault_evt)
      state_nxt.ind_n = 1'b0;

    if (reset) begin
      state_nxt              = '0;
      state_nxt.ind_n        = 1'b1;
      state_nxt.width_first  = `WIDTH_FIRST_RESET;
      state_nxt.width_second = `WIDTH_SECOND_RESET;
      state_nxt.retry_limit  = `RETRY_LIMIT_RESET;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign apb_rsp           = state_r.rsp;
  assign channel_on        = state_r.on;
  assign fault_indicator_n = state_r.ind_n;
  assign sense_sync        = state_r.blank;
  assign retry_restart     = state_r.retry_pend;

  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  a_ot_shutdown: assert property (
    cmp.ch[0].hot |=> !channel_on[0] && state_r.ot_flag[0] &&
                      !fault_indicator_n)
    else $error("overtemperature did not stop channel 0");

  a_ind_cool_rise: assert property (
    $rose(fault_indicator_n) && !$past(state_r.uv_d) |->
      $past(both_cool) && (channel_on & ~$past(channel_on)) != 2'b00)
    else $error("indicator rose without a cool turn-on");

  a_ot_off_low: assert property (
    cmp.ch[1].hot && !channel_on[1] |=> !fault_indicator_n [*1]
      ##1 (!fault_indicator_n || !$past(cmp.ch[1].hot)))
    else $error("indicator released while channel 1 hot");

  a_ot_read_clear: assert property (
    $fell(state_r.ot_flag[0]) |-> $past(rd_fault0) &&
                                  $past(fault_indicator_n))
    else $error("ot flag cleared without qualified read");

  a_oc_response: assert property (
    $rose(state_r.oc_pend[0]) && !$past(reset) |-> ##2
      (!channel_on[0] && state_r.oc_flag[0] && !fault_indicator_n))
    else $error("overcurrent response time not met");

  a_blank_window: assert property (
    $rose(channel_on[0]) && !$past(chan_ctl.switch_mode[0]) &&
      !$past(cmp.load_profile_select[0] ^ state_r.src_sel[0]) |->
      sense_sync[0])
    else $error("sense not blanked at turn-on");

  a_latch_retries: assert property (
    $rose(state_r.latch_oc[1]) |-> $past(!state_r.retry_en[1] ||
      state_r.retries[1] >= state_r.retry_limit))
    else $error("overcurrent latched with retries left");

  a_delatch_clear: assert property (
    chan_ctl.delatch[0] |=> state_r.dur[0] == 16'h0000 &&
                            !state_r.latch_oc[0])
    else $error("delatch did not clear the counter");

  a_ov_both_off: assert property (
    cmp.sup.overvolt && !state_r.ovdis |=> channel_on == 2'b00 &&
      !fault_indicator_n && state_r.ov_flag)
    else $error("overvoltage did not stop both channels");

  a_ov_warn_only: assert property (
    cmp.sup.overvolt && state_r.ovdis && !state_r.ov_block |=>
      state_r.ov_flag && !state_r.ov_block)
    else $error("disabled overvoltage acted as a fault");

  a_uv_both_off: assert property (
    cmp.sup.undervolt |=> channel_on == 2'b00 && state_r.uv_flag &&
                          !fault_indicator_n)
    else $error("undervoltage did not stop both channels");

  c_auto_retry: cover property ($rose(retry_restart[0]));
  c_second_window: cover property (state_r.phase[0] == WIN_SECOND);
  c_ov_release: cover property ($fell(state_r.ov_block));
  c_oc_latched: cover property ($rose(state_r.latch_oc[0]));

endmodule

// [test/comparator_model.sv]
// behavioural comparators and strap pins in front of the fault block
// assumes the bench sets analog levels; outputs are plain levels
`timescale 1ns/1ps
module comparator_model (
  // analog levels from the bench
  input  wire logic [1:0]      hot,
  input  wire logic [1:0][1:0] load,
  input  wire logic [1:0]      shorted,
  input  wire logic [1:0]      supply,
  input  wire logic [1:0]      strap,
  // comparator outputs
  output fault_pkg::pin_in_t   pins
);
  import fault_pkg::*;
  // supply 0 under, 1 normal, 2 over, 3 falling but above release
  // load 0 none, 1 above low, 2 above mid, 3 above high threshold
  always_comb begin
    pins = '0;
    pins.load_profile_select = strap;
    pins.sup.undervolt = supply == 2'h0;
    pins.sup.overvolt = supply == 2'h2;
    pins.sup.ov_released = supply <= 2'h1;
    for (int i = 0; i < 2; i++) begin
      pins.ch[i].hot = hot[i];
      pins.ch[i].over_low = load[i] >= 2'h1;
      pins.ch[i].over_mid = load[i] >= 2'h2;
      pins.ch[i].over_high = load[i] == 2'h3;
      pins.ch[i].short_det = shorted[i];
    end
  end
endmodule

// [test/switch_fault_protection_bench.sv]
// self-checking bench for the switch fault protection block
// assumes one 100 MHz clock and the apb map of the fault header
`timescale 1ns/1ps
`include "fault_regs.svh"
module switch_fault_protection_bench;
  import fault_pkg::*;
  localparam logic [11:0] GC = `GENERAL_CFG_OFFSET;
  localparam logic [11:0] F0 = `CHAN_FAULT0_OFFSET;
  localparam logic [11:0] F1 = `CHAN_FAULT1_OFFSET;
  localparam logic [11:0] ST = `COMMON_STATUS_OFFSET;
  logic            clock;
  logic            reset;
  apb_req_t        req;
  apb_rsp_t        rsp;
  pin_in_t         pins;
  chan_ctl_t       ctl;
  logic [1:0]      chan_on;
  logic [1:0]      sync;
  logic [1:0]      restart;
  logic            ind_n;
  logic [1:0]      hot;
  logic [1:0]      shorted;
  logic [1:0]      supply;
  logic [1:0]      strap;
  logic [1:0]      sel;
  logic [1:0]      rnd;
  logic [1:0][1:0] load;
  logic [31:0]     q;
  logic [31:0]     pulses;
  logic            err;
  int              fails;
  int              samples_checked;

  comparator_model comparator_model_i (
    .hot(hot), .load(load), .shorted(shorted), .supply(supply),
    .strap(strap), .pins(pins));
  switch_fault_protection switch_fault_protection_i (
    .clock(clock), .reset(reset), .apb_req(req), .apb_rsp(rsp),
    .fault_pins(pins), .chan_ctl(ctl), .channel_on(chan_on),
    .fault_indicator_n(ind_n), .sense_sync(sync),
    .retry_restart(restart));

  always #5 clock = ~clock;

  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  task check(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task bit_chk(input string what, input logic seen, input logic exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  // request held until pready is sampled; no latency assumed
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    tick(1);
    req.penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    tick(1);
  endtask

  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // every scenario starts from reset so earlier latches do not leak
  task rst(input int n);
    reset <= 1'b1;
    ctl <= '0;
    hot <= '0;
    load <= '0;
    shorted <= '0;
    supply <= 2'h1;
    tick(n);
    reset <= 1'b0;
    tick(3);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    tick(20000);
    fails++;
    wrap_up();
  end

  initial begin
    clock = 1'b0;
    reset = 1'b1;
    req = '0;
    ctl = '0;
    hot = '0;
    load = '0;
    shorted = '0;
    supply = 2'h1;
    strap = '0;
    fails = 0;
    samples_checked = 0;
    void'($urandom(32'h333d680d));
    rst(20);
    check("idle outputs", {27'h0, chan_on, ind_n, sync}, 32'h4);
    rd(GC); check("gcfg reset", q, 32'h0);
    rd(`OC_CFG_OFFSET);
    check("ocfg reset", q, {`WIDTH_SECOND_RESET, `WIDTH_FIRST_RESET});
    rd(12'h014); bit_chk("unmapped err", err, 1'b1);
    check("unmapped data", q, 32'h0);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      rnd = 2'($urandom);
      strap <= {rnd[0], sel[0]};
      apb(1'b1, GC, {29'h0, rnd[1], sel[1], 1'b0});
      tick(3);
      rd(F0); bit_chk("profile ch0", q[3], sel[0] ^ sel[1]);
      rd(F1); bit_chk("profile ch1", q[3], rnd[0] ^ rnd[1]);
    end
    // lighting windows shortened so the steady threshold is reached
    rst(2);
    strap <= 2'h0;
    apb(1'b1, `OC_CFG_OFFSET, {16'h8, 16'h8});
    ctl.request <= 2'h1;
    tick(4);
    bit_chk("blank in window", sync[0], 1'b1);
    tick(40);
    bit_chk("blank after window", sync[0], 1'b0);
    bit_chk("on after window", chan_on[0], 1'b1);
    load <= 2'h1;
    tick(10);
    bit_chk("oc off", chan_on[0], 1'b0);
    bit_chk("oc indicator", ind_n, 1'b0);
    rd(F0); bit_chk("oc flag", q[0], 1'b1);
    rst(2);
    ctl.request <= 2'h1;
    tick(4);
    hot <= 2'h1;
    tick(6);
    bit_chk("ot off", chan_on[0], 1'b0);
    bit_chk("ot indicator", ind_n, 1'b0);
    rd(F0); bit_chk("ot flag", q[2], 1'b1);
    hot <= 2'h0;
    tick(6);
    bit_chk("ind held cool", ind_n, 1'b0);
    ctl.request <= 2'h0;
    tick(2);
    ctl.request <= 2'h1;
    tick(4);
    bit_chk("ind on turn on", ind_n, 1'b1);
    rd(F0); bit_chk("ot flag kept", q[2], 1'b1);
    rd(F0); bit_chk("ot flag read", q[2], 1'b0);
    hot <= 2'h2;
    tick(6);
    bit_chk("ot while off", ind_n, 1'b0);
    bit_chk("other on", chan_on[0], 1'b1);
    rst(2);
    apb(1'b1, GC, 32'h108);
    ctl.request <= 2'h1;
    tick(4);
    hot <= 2'h1;
    tick(6);
    hot <= 2'h0;
    tick(6);
    bit_chk("ot retry", chan_on[0], 1'b1);
    rst(2);
    apb(1'b1, GC, 32'h208);
    load <= 2'h3;
    ctl.request <= 2'h1;
    pulses = '0;
    repeat (60) begin
      tick(1);
      pulses = pulses + {31'h0, restart[0]};
    end
    check("retry pulses", pulses, 32'h2);
    bit_chk("oc latched", chan_on[0], 1'b0);
    rd(F0); check("retries used", {27'h0, q[7:4], q[0]}, 32'h5);
    // delatch with the load gone lets the held request run again
    load <= 2'h0;
    tick(3);
    ctl.delatch <= 2'h1;
    tick(1);
    ctl.delatch <= 2'h0;
    tick(3);
    bit_chk("delatch on", chan_on[0], 1'b1);
    rd(F0); check("delatch retries", {28'h0, q[7:4]}, 32'h0);
    rst(2);
    shorted <= 2'h2;
    ctl.request <= 2'h2;
    tick(8);
    bit_chk("short off", chan_on[1], 1'b0);
    bit_chk("short ind", ind_n, 1'b0);
    rd(F1); bit_chk("short flag", q[1], 1'b1);
    rst(2);
    ctl.request <= 2'h3;
    tick(4);
    supply <= 2'h0;
    tick(6);
    check("uv off", {30'h0, chan_on}, 32'h0);
    bit_chk("uv ind", ind_n, 1'b0);
    rd(ST); bit_chk("uv flag", q[1], 1'b1);
    ctl.request <= 2'h0;
    supply <= 2'h1;
    tick(6);
    bit_chk("uv gone ind", ind_n, 1'b1);
    rd(ST); bit_chk("uv kept", q[1], 1'b1);
    ctl.request <= 2'h3;
    tick(4);
    supply <= 2'h2;
    tick(6);
    check("ov off", {30'h0, chan_on}, 32'h0);
    bit_chk("ov ind", ind_n, 1'b0);
    supply <= 2'h3;
    tick(6);
    check("ov hysteresis", {30'h0, chan_on}, 32'h0);
    supply <= 2'h1;
    tick(6);
    check("ov released", {30'h0, chan_on}, 32'h3);
    rd(ST); bit_chk("ov flag", q[0], 1'b1);
    rd(ST); check("status read", {30'h0, q[1:0]}, 32'h0);
    apb(1'b1, GC, 32'h1);
    supply <= 2'h2;
    tick(6);
    check("ov disabled", {30'h0, chan_on}, 32'h3);
    bit_chk("overvolt_protect_disable ind", ind_n, 1'b1);
    rd(ST); bit_chk("ov warning", q[0], 1'b1);
    // motor profile in switch mode: only on-time fills the window
    rst(2);
    strap <= 2'h1;
    apb(1'b1, `OC_CFG_OFFSET, {16'h8, 16'h8});
    ctl.switch_mode <= 2'h1;
    load <= 2'h1;
    tick(3);
    for (int p = 0; p < 2; p++) begin
      ctl.request <= 2'h1;
      tick(6);
      ctl.request <= 2'h0;
      tick(6);
      rd(F0); bit_chk("switch mode trip", q[0], p[0]);
    end
    wrap_up();
  end
endmodule
